// *** rtl/hms_pkg.sv ***
// Constants, types and method decoding for the homing sequencer.
// Assumes one control clock; all inputs already synchronous to it.
package hms_pkg;

  // ----------------------------------------------------------------
  // Widths and directions
  // ----------------------------------------------------------------
  localparam int METHOD_W = 8;        // Method-select width
  localparam int POS_W = 32;          // Encoder position width
  localparam logic DIR_POS = 1'b1;    // Positive travel
  localparam logic DIR_NEG = 1'b0;    // Negative travel
  localparam logic [31:0] HOME_RESET = 32'h0000_0000; // Latched home at reset

  // ----------------------------------------------------------------
  // Method numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] METHOD_05 = 8'h05;
  localparam logic [7:0] METHOD_06 = 8'h06;
  localparam logic [7:0] METHOD_07 = 8'h07;
  localparam logic [7:0] METHOD_08 = 8'h08;
  localparam logic [7:0] METHOD_09 = 8'h09;
  localparam logic [7:0] METHOD_10 = 8'h0a;
  localparam logic [7:0] METHOD_11 = 8'h0b;
  localparam logic [7:0] METHOD_12 = 8'h0c;
  localparam logic [7:0] METHOD_13 = 8'h0d;
  localparam logic [7:0] METHOD_17 = 8'h11;
  localparam logic [7:0] METHOD_18 = 8'h12;
  localparam logic [7:0] METHOD_19 = 8'h13;
  localparam logic [7:0] METHOD_20 = 8'h14;
  localparam logic [7:0] METHOD_21 = 8'h15;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {hms_src_switch, hms_src_neg_limit,
    hms_src_pos_limit} hms_src_t;     // Which sensor defines the event
  typedef enum logic [1:0] {hms_edge_rise, hms_edge_fall,
    hms_edge_any} hms_edge_t;         // Which transition counts
  typedef enum logic [1:0] {hms_qual_pos, hms_qual_neg,
    hms_qual_any} hms_qual_t;         // Travel direction that counts
  typedef enum logic [1:0] {hms_idle, hms_search,
    hms_creep} hms_state_t;           // Sequencer phase

  // Decoded method description
  typedef struct packed {
    logic supported;      // Method implemented here
    logic dir_inactive;   // Start direction, switch inactive
    logic dir_active;     // Start direction, switch active
    hms_src_t src;        // Event sensor
    hms_edge_t edge_kind; // Event transition
    hms_qual_t qual;      // Event direction qualifier
    logic creep_dir;      // Direction of the low-speed phase
    logic seek_index;     // Home is the next index pulse
  } hms_info_t;

  // ----------------------------------------------------------------
  // Method decode
  // ----------------------------------------------------------------
  function automatic hms_info_t hms_decode(input logic [7:0] m);
    hms_info_t info;
    info = '0;
    case (m)
      // RULE2 method 5 entry
      METHOD_05: info = '{1'b1, DIR_NEG, DIR_POS, hms_src_switch,
        hms_edge_fall, hms_qual_pos, DIR_POS, 1'b1};
      // RULE3 method 6 entry
      METHOD_06: info = '{1'b1, DIR_NEG, DIR_POS, hms_src_switch,
        hms_edge_fall, hms_qual_neg, DIR_NEG, 1'b1};
      // RULE4 method 7 entry
      METHOD_07: info = '{1'b1, DIR_POS, DIR_NEG, hms_src_switch,
        hms_edge_fall, hms_qual_neg, DIR_NEG, 1'b1};
      // RULE5 method 8 entry
      METHOD_08: info = '{1'b1, DIR_POS, DIR_NEG, hms_src_switch,
        hms_edge_rise, hms_qual_pos, DIR_POS, 1'b1};
      // RULE6 method 9 entry
      METHOD_09: info = '{1'b1, DIR_POS, DIR_POS, hms_src_switch,
        hms_edge_rise, hms_qual_neg, DIR_NEG, 1'b1};
      // RULE7 method 10 entry
      METHOD_10: info = '{1'b1, DIR_POS, DIR_POS, hms_src_switch,
        hms_edge_fall, hms_qual_pos, DIR_POS, 1'b1};
      // RULE8 method 11 entry
      METHOD_11: info = '{1'b1, DIR_NEG, DIR_POS, hms_src_switch,
        hms_edge_fall, hms_qual_pos, DIR_POS, 1'b1};
      // RULE9 method 12 entry
      METHOD_12: info = '{1'b1, DIR_NEG, DIR_POS, hms_src_switch,
        hms_edge_rise, hms_qual_any, DIR_NEG, 1'b1};
      // RULE10 method 13 entry
      METHOD_13: info = '{1'b1, DIR_NEG, DIR_NEG, hms_src_switch,
        hms_edge_any, hms_qual_pos, DIR_POS, 1'b1};
      // RULE12 negative limit home
      METHOD_17: info = '{1'b1, DIR_NEG, DIR_NEG, hms_src_neg_limit,
        hms_edge_rise, hms_qual_any, DIR_NEG, 1'b0};
      // RULE13 positive limit home
      METHOD_18: info = '{1'b1, DIR_POS, DIR_POS, hms_src_pos_limit,
        hms_edge_rise, hms_qual_pos, DIR_POS, 1'b0};
      // RULE14 switch edge home
      METHOD_19: info = '{1'b1, DIR_POS, DIR_NEG, hms_src_switch,
        hms_edge_rise, hms_qual_any, DIR_POS, 1'b0};
      // RULE15 switch edge positive
      METHOD_20: info = '{1'b1, DIR_POS, DIR_NEG, hms_src_switch,
        hms_edge_rise, hms_qual_pos, DIR_POS, 1'b0};
      // RULE16 switch edge home
      METHOD_21: info = '{1'b1, DIR_NEG, DIR_POS, hms_src_switch,
        hms_edge_rise, hms_qual_any, DIR_POS, 1'b0};
      default: info = '0;
    endcase
    return info;
  endfunction : hms_decode

endpackage : hms_pkg

// *** rtl/hms_sense_if.sv ***
// Edge information passed from the sensor edge detector to the sequencer.
// Assumes both ends run on the same control clock.
interface hms_sense_if;
  logic sw_rise;   // Home switch inactive to active
  logic sw_fall;   // Home switch active to inactive
  logic nl_rise;   // Negative limit becomes active
  logic pl_rise;   // Positive limit becomes active
  logic idx_rise;  // Encoder index pulse edge
  modport producer (output sw_rise, sw_fall, nl_rise, pl_rise, idx_rise);
  modport consumer (input sw_rise, sw_fall, nl_rise, pl_rise, idx_rise);
endinterface : hms_sense_if

// *** rtl/hms_edge_detect.sv ***
// Transition detector for the home switch, both limits and the index.
// Assumes active-high sensor levels synchronous to ref_clk.
module hms_edge_detect
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic home_switch,
  input wire logic negative_limit,
  input wire logic positive_limit,
  input wire logic index_pulse,
  hms_sense_if.producer sense
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic primed;  // One sample taken since reset
    logic sw;      // Previous home switch
    logic nl;      // Previous negative limit
    logic pl;      // Previous positive limit
    logic idx;     // Previous index
  } hms_edge_state_t;

  hms_edge_state_t st;       // Registered samples
  hms_edge_state_t next_st;  // Next samples

  // Sample all levels each cycle
  always_comb
  begin
    next_st = st;
    next_st.primed = 1'b1;
    next_st.sw = home_switch;
    next_st.nl = negative_limit;
    next_st.pl = positive_limit;
    next_st.idx = index_pulse;
  end

  // Register; reset clears every sample
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Edges
  // ----------------------------------------------------------------
  // RULE1 separate transition detection
  // Gated until primed, so a sensor already active at reset is no edge
  assign sense.sw_rise = st.primed & home_switch & ~st.sw;
  assign sense.sw_fall = st.primed & ~home_switch & st.sw;
  assign sense.nl_rise = st.primed & negative_limit & ~st.nl;
  assign sense.pl_rise = st.primed & positive_limit & ~st.pl;
  assign sense.idx_rise = st.primed & index_pulse & ~st.idx;

endmodule : hms_edge_detect

// *** rtl/hms_homing_sequencer.sv ***
// Homing sequencer: method decode, search, creep and home latch.
// Assumes sensor levels and position synchronous to ref_clk, and a
// motion stage that follows motion_enable, move_positive, high_speed.

//
// Function
// RULE1 - Switch and limits give distinct edges
// RULE2 - Method 5: fall positive, creep positive
// RULE3 - Method 6: fall negative, creep negative
// RULE4 - Method 7: fall negative, creep negative
// RULE5 - Method 8: rise positive, creep positive
// RULE6 - Method 9: start positive, rise negative
// RULE7 - Method 10: start positive, fall positive
// RULE8 - Method 11: fall positive, low speed
// RULE9 - Method 12: rise, creep negative to index
// RULE10 - Method 13: start negative, creep positive
// RULE11 - Creep keeps direction until index
// RULE12 - Negative limit edge is home
// RULE13 - Positive limit edge is home
// RULE14 - Method 3 variant: switch rise home
// RULE15 - Method 4 variant: rise positive home
// RULE16 - Method 5 variant: switch rise home
// RULE17 - High speed until switching condition
// RULE18 - Latch position, stop, signal done
module hms_homing_sequencer
#(
  parameter int POS_W = hms_pkg::POS_W
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] method,
  input wire logic home_switch,
  input wire logic negative_limit,
  input wire logic positive_limit,
  input wire logic index_pulse,
  input wire logic [POS_W-1:0] position,
  output logic motion_enable,
  output logic move_positive,
  output logic high_speed,
  output logic homing_busy,
  output logic homing_done,
  output logic homing_error,
  output logic [POS_W-1:0] home_position
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hms_pkg::hms_state_t state;  // Phase
    hms_pkg::hms_info_t info;    // Active method
    logic motion;                // Drive motion
    logic dir;                   // Travel direction
    logic fast;                  // Search speed selected
    logic busy;                  // Homing in progress
    logic done;                  // One-cycle completion
    logic error;                 // Last request failed
    logic [POS_W-1:0] home;      // Latched home position
  } hms_seq_state_t;

  hms_seq_state_t st;        // Registered state
  hms_seq_state_t next_st;   // Next state
  hms_pkg::hms_info_t start_info;  // Decode of the requested method
  logic hit;                 // Method's switching event this cycle
  logic src_edge;            // Selected sensor edge seen
  logic dir_ok;              // Direction qualifier met
  logic limit_ahead;         // Limit reached in travel direction

  hms_sense_if sense ();     // Edge bundle from the detector

  // ----------------------------------------------------------------
  // Sensor edges
  // ----------------------------------------------------------------
  hms_edge_detect u_edges
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .home_switch(home_switch),
    .negative_limit(negative_limit),
    .positive_limit(positive_limit),
    .index_pulse(index_pulse),
    .sense(sense)
  );

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  // Pick the defining edge of the active method
  always_comb
  begin
    // RULE2 method 5 decode
    // RULE3 method 6 decode
    // RULE4 method 7 decode
    // RULE5 method 8 decode
    // RULE6 method 9 decode
    // RULE7 method 10 decode
    // RULE8 method 11 decode
    // RULE9 method 12 decode
    // RULE10 method 13 decode
    // RULE12 method 17 decode
    // RULE13 method 18 decode
    // RULE14 method 19 decode
    // RULE15 method 20 decode
    // RULE16 method 21 decode
    start_info = hms_pkg::hms_decode(method);
    src_edge = 1'b0;
    dir_ok = 1'b0;
    // RULE1 edge by sensor
    case (st.info.src)
      hms_pkg::hms_src_neg_limit: src_edge = sense.nl_rise;
      hms_pkg::hms_src_pos_limit: src_edge = sense.pl_rise;
      default:
      begin
        case (st.info.edge_kind)
          hms_pkg::hms_edge_rise: src_edge = sense.sw_rise;
          hms_pkg::hms_edge_fall: src_edge = sense.sw_fall;
          default: src_edge = sense.sw_rise | sense.sw_fall;
        endcase
      end
    endcase
    // Edge counts only in the method's travel direction; hms_qual_any counts it in both
    case (st.info.qual)
      hms_pkg::hms_qual_pos: dir_ok = st.dir == hms_pkg::DIR_POS;
      hms_pkg::hms_qual_neg: dir_ok = st.dir == hms_pkg::DIR_NEG;
      default: dir_ok = 1'b1;
    endcase
    hit = src_edge & dir_ok;
    // Limit in the way; a search turns back, a creep aborts with an error
    limit_ahead = st.dir ? sense.pl_rise : sense.nl_rise;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state; a new supported request restarts homing from any phase
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (start)
    begin
      if (!start_info.supported)
      begin
        // Unknown method: refuse and stay still
        next_st.state = hms_pkg::hms_idle;
        next_st.motion = 1'b0;
        next_st.busy = 1'b0;
        next_st.error = 1'b1;
      end
      else
      begin
        // RULE17 search starts fast
        next_st.state = hms_pkg::hms_search;
        next_st.info = start_info;
        next_st.fast = 1'b1;
        next_st.motion = 1'b1;
        next_st.busy = 1'b1;
        next_st.error = 1'b0;
        // Start direction from the switch level at the request
        next_st.dir = home_switch ? start_info.dir_active :
          start_info.dir_inactive;
      end
    end
    else
    begin
      case (st.state)
        hms_pkg::hms_idle:
        begin
          // Nothing moves while idle
          next_st.motion = 1'b0;
        end
        hms_pkg::hms_search:
        begin
          if (hit && st.info.seek_index)
          begin
            // RULE17 creep only after the event
            next_st.state = hms_pkg::hms_creep;
            next_st.fast = 1'b0;
            next_st.dir = st.info.creep_dir;
          end
          else if (hit)
          begin
            // RULE18 edge defines home
            next_st.state = hms_pkg::hms_idle;
            next_st.home = position;
            next_st.motion = 1'b0;
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
          end
          else if (limit_ahead)
          begin
            // Reverse at a limit so the wanted edge can still come
            next_st.dir = ~st.dir;
          end
        end
        hms_pkg::hms_creep:
        begin
          if (sense.idx_rise)
          begin
            // RULE11 index at creep end
            // RULE18 latch and stop
            next_st.state = hms_pkg::hms_idle;
            next_st.home = position;
            next_st.motion = 1'b0;
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
          end
          else if (limit_ahead)
          begin
            // No index before the limit: abort with error
            next_st.state = hms_pkg::hms_idle;
            next_st.motion = 1'b0;
            next_st.busy = 1'b0;
            next_st.error = 1'b1;
          end
        end
        default:
        begin
          next_st.state = hms_pkg::hms_idle;
          next_st.motion = 1'b0;
        end
      endcase
    end
  end

  // Register; reset leaves the axis stopped with no home known
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.home <= POS_W'(hms_pkg::HOME_RESET);
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign motion_enable = st.motion;
  assign move_positive = st.dir;
  assign high_speed = st.fast;
  assign homing_busy = st.busy;
  assign homing_done = st.done;
  assign homing_error = st.error;
  assign home_position = st.home;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start_ok;
    start && start_info.supported;
  endsequence

  sequence s_fast_search;
    st.state == hms_pkg::hms_search && motion_enable && high_speed;
  endsequence

  sequence s_switch_event;
    !start && st.state == hms_pkg::hms_search && hit;
  endsequence

  a_start_fast: assert property ( // RULE17
    @(posedge ref_clk) disable iff (reset)
    s_start_ok |=> s_fast_search)
    else $error("search did not start at high speed");

  a_start_direction: assert property ( // RULE3
    @(posedge ref_clk) disable iff (reset)
    s_start_ok |=> move_positive ==
    ($past(home_switch) ? $past(start_info.dir_active) :
    $past(start_info.dir_inactive)))
    else $error("wrong start direction");

  a_switch_creep: assert property ( // RULE2
    @(posedge ref_clk) disable iff (reset)
    s_switch_event ##0 st.info.seek_index |=> !high_speed &&
    st.state == hms_pkg::hms_creep && move_positive ==
    $past(st.info.creep_dir))
    else $error("no creep after switching event");

  a_edge_home: assert property ( // RULE12
    @(posedge ref_clk) disable iff (reset)
    s_switch_event ##0 !st.info.seek_index |=> homing_done &&
    home_position == $past(position))
    else $error("edge method did not latch home");

  a_index_home: assert property ( // RULE11
    @(posedge ref_clk) disable iff (reset)
    !start && st.state == hms_pkg::hms_creep && sense.idx_rise |=>
    homing_done && !motion_enable && home_position == $past(position))
    else $error("index did not end creep");

  a_creep_steady: assert property ( // RULE11
    @(posedge ref_clk) disable iff (reset)
    !start && st.state == hms_pkg::hms_creep && !sense.idx_rise &&
    !limit_ahead |=> $stable(move_positive) && !high_speed &&
    motion_enable)
    else $error("creep changed direction or speed");

  a_done_stops: assert property ( // RULE18
    @(posedge ref_clk) disable iff (reset)
    homing_done |-> !motion_enable && !homing_busy ##1 !homing_done)
    else $error("done without stopping");

  a_fast_hold: assert property ( // RULE17
    @(posedge ref_clk) disable iff (reset)
    s_fast_search ##0 !start && !hit |=> high_speed)
    else $error("speed dropped before event");

  a_bad_method: assert property ( // RULE17
    @(posedge ref_clk) disable iff (reset)
    start && !start_info.supported |=>
    (homing_error && !motion_enable) [*2])
    else $error("unsupported method moved the axis");

endmodule : hms_homing_sequencer

// *** sim/hms_axis_model.sv ***
// Axis model for the homing bench: motor, encoder, index and sensors.
// Assumes the sequencer's motion outputs settle after the rising edge.
module hms_axis_model
#(
  parameter int SW_LO = 416,
  parameter int SW_HI = 480,
  parameter int NEG_AT = 40,
  parameter int POS_AT = 900,
  parameter int PITCH = 64
)
(
  input wire logic ref_clk,
  input wire logic motion_enable,
  input wire logic move_positive,
  input wire logic high_speed,
  input wire logic load,
  input wire logic [31:0] load_pos,
  output logic home_switch,
  output logic negative_limit,
  output logic positive_limit,
  output logic index_pulse,
  output logic [31:0] position
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Shaft motion
  // ----------------------------------------------------------------
  int p = 0; // Shaft position in counts

  // Moves on the falling edge; search steps 4 counts, creep 1, so the
  // index is never jumped over once aligned starts are used
  always @(negedge ref_clk)
  begin
    if (load)
      p <= int'(load_pos);
    else if (motion_enable)
      p <= move_positive ? p + (high_speed ? 4 : 1) : p - (high_speed ? 4 : 1);
  end

  // ----------------------------------------------------------------
  // Sensors, all active high, pure functions of position
  // ----------------------------------------------------------------
  assign position = p[31:0];
  assign home_switch = (p >= SW_LO) && (p <= SW_HI);
  assign negative_limit = (p <= NEG_AT);
  assign positive_limit = (p >= POS_AT);
  // Index stays high while parked on it; only a new arrival is an edge
  assign index_pulse = ((p % PITCH) == 0);

endmodule : hms_axis_model

// *** sim/homing_method_sequencer_tb_top.sv ***
// Self-checking bench for the homing sequencer and its axis model.
// Assumes the axis model's geometry matches the constants below.
module homing_method_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic [7:0] method = 8'h00;
  logic load = 1'b1;
  logic [31:0] load_pos = 32'h0000_00c8;
  logic home_switch, negative_limit, positive_limit, index_pulse;
  logic [31:0] position, home_position;
  logic motion_enable, move_positive, high_speed;
  logic homing_busy, homing_done, homing_error;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] rng = 32'h0000_0664; // Fixed seed
  int ml[14] = '{5, 6, 7, 8, 9, 10, 11, 12, 13, 17, 18, 19, 20, 21};
  int bad[7] = '{0, 1, 4, 14, 16, 22, 255}; // Not implemented here

  always #12.5 ref_clk = ~ref_clk;

  hms_homing_sequencer dut (.ref_clk(ref_clk), .reset(reset),
    .start(start), .method(method), .home_switch(home_switch),
    .negative_limit(negative_limit), .positive_limit(positive_limit),
    .index_pulse(index_pulse), .position(position),
    .motion_enable(motion_enable), .move_positive(move_positive),
    .high_speed(high_speed), .homing_busy(homing_busy),
    .homing_done(homing_done), .homing_error(homing_error),
    .home_position(home_position));

  hms_axis_model axis (.ref_clk(ref_clk), .motion_enable(motion_enable),
    .move_positive(move_positive), .high_speed(high_speed), .load(load),
    .load_pos(load_pos), .home_switch(home_switch),
    .negative_limit(negative_limit), .positive_limit(positive_limit),
    .index_pulse(index_pulse), .position(position));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xorshift

  // Nibbles: sensor, dir idle, dir active, edge, travel, creep, index
  function automatic logic [27:0] mtab(input int m);
    case (m)
      5, 11: return 28'h0011011;
      6: return 28'h0011101;
      7: return 28'h0101101;
      8: return 28'h0100011;
      9: return 28'h0110101;
      10: return 28'h0111011;
      12: return 28'h0010201;
      13: return 28'h0002011;
      17: return 28'h1000200;
      18: return 28'h2110010;
      19: return 28'h0100210;
      20: return 28'h0100010;
      21: return 28'h0010210;
      default: return 28'h0;
    endcase
  endfunction : mtab

  // Sensor level at a position: 0 switch, 1 negative, 2 positive limit
  function automatic bit sens(input int p, input int s);
    if (s == 1)
      return p <= 40;
    if (s == 2)
      return p >= 900;
    return (p >= 416) && (p <= 480);
  endfunction : sens

  // Walks the axis in search steps until the event, then finds home
  task automatic predict(input int m, input int p0, output int d0,
    output int ev, output int home);
    int p, o, d, e, q, src, n;
    logic [27:0] t;
    t = mtab(m);
    src = t[27:24];
    e = t[15:12];
    q = t[11:8];
    d = sens(p0, 0) ? t[16] : t[20];
    d0 = d;
    p = p0;
    for (n = 0; n < 3000; n++)
    begin
      o = p;
      p = d ? p + 4 : p - 4;
      if (((e == 0 && !sens(o, src) && sens(p, src))
        || (e == 1 && sens(o, src) && !sens(p, src))
        || (e == 2 && sens(o, src) != sens(p, src)))
        && (q == 2 || q == (d ? 0 : 1)))
        break;
      // A limit in the travel direction turns the search round
      if (d && src != 2 && !sens(o, 2) && sens(p, 2))
        d = 0;
      else if (!d && src != 1 && !sens(o, 1) && sens(p, 1))
        d = 1;
    end
    ev = p;
    home = (t[3:0] == 0) ? p :
      (t[4] ? (p / 64 + 1) * 64 : ((p - 1) / 64) * 64);
  endtask : predict

  // ----------------------------------------------------------------
  // Checking and drivers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what,
        got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Parks the axis; two idle cycles so the load is not taken as an edge
  task automatic load_at(input int p0);
    @(negedge ref_clk);
    load = 1'b1;
    load_pos = p0[31:0];
    @(negedge ref_clk);
    load = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : load_at

  // One-cycle homing request, entered and left on a falling edge
  task automatic kick(input int m);
    start = 1'b1;
    method = m[7:0];
    @(negedge ref_clk);
    start = 1'b0;
  endtask : kick

  task automatic go(input int m, input int p0);
    int d0, ev, home, cp, n;
    logic [27:0] t;
    t = mtab(m);
    load_at(p0);
    predict(m, p0, d0, ev, home);
    kick(m);
    if (t == 28'h0)
    begin
      chk(homing_error, 1, "refused flag");
      chk(motion_enable | homing_busy, 0, "refused motion");
      return;
    end
    chk(homing_error, 0, "error cleared");
    chk(move_positive, d0, "start direction");
    chk(high_speed & motion_enable & homing_busy, 1, "search");
    cp = -1;
    for (n = 0; n < 4000 && homing_done !== 1'b1 && homing_error !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (cp < 0 && high_speed === 1'b0 && motion_enable === 1'b1)
        cp = int'(position);
    end
    chk(homing_done, 1, "completion");
    chk(home_position, home, "home position");
    chk(motion_enable | homing_busy, 0, "stopped");
    chk((t[3:0] == 0) ? (cp == -1) : (cp >= ev - 12 && cp <= ev + 12), 1,
      "creep start");
    @(posedge ref_clk);
    #1;
    chk(homing_done, 0, "done width");
  endtask : go

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    // Every method from a random spot and from inside the switch
    foreach (ml[i])
    begin
      go(ml[i], 100 + int'(xorshift() % 32'd176) * 4);
      go(ml[i], 448);
    end
    foreach (bad[i])
      go(bad[i], 200);
    // A refused request aborts a run in progress
    load_at(200);
    kick(10);
    repeat (10) @(negedge ref_clk);
    kick(14);
    chk(homing_error, 1, "abort error");
    chk(motion_enable | homing_busy, 0, "abort stops");
    go(8, 300);
    // A limit met while creeping ends the run with an error; the axis
    // is jumped past the positive limit once the creep has begun
    load_at(448);
    kick(5);
    while (high_speed !== 1'b0)
      @(negedge ref_clk);
    load = 1'b1;
    load_pos = 32'h0000_0388;
    @(negedge ref_clk);
    load = 1'b0;
    @(negedge ref_clk);
    chk(homing_error, 1, "creep limit error");
    chk(motion_enable | homing_busy | homing_done, 0, "creep stop");
    // Reset in mid-run clears everything, the latched home too
    load_at(200);
    kick(9);
    repeat (20) @(negedge ref_clk);
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(motion_enable | homing_busy | homing_done | homing_error, 0,
      "reset");
    chk(home_position, hms_pkg::HOME_RESET, "reset home");
    reset = 1'b0;
    tally_and_finish();
  end

  // Watchdog well beyond the longest expected run
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end

endmodule : homing_method_sequencer_tb_top
